// >>> core/cies_core.sv
// Executes a subset of an 8-bit core's instructions, one word per instruction cycle.
// Assumes program memory answers pc_o combinationally on instr_i, the return
// stack and watchdog timer sit outside, and all inputs are synchronous to clk_i.
`timescale 1ns/1ps
`include "cies_cfg.svh"
module cies_core
   import cies_pkg::*;
#(
   parameter int INSTR_W = `CIES_INSTR_W,
   parameter int PC_W    = `CIES_PC_W,
   parameter int DATA_W  = `CIES_DATA_W,
   parameter int FADDR_W = `CIES_FADDR_W,
   parameter int DEPTH   = `CIES_FILE_DEPTH
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 run_i,
   input  wire logic [INSTR_W-1:0]   instr_i,
   output logic      [PC_W-1:0]      pc_o,
   input  wire logic [6:0]           pc_high_latch_i,
   output logic                      push_o,
   output logic      [PC_W-1:0]      stack_top_o,
   output logic                      watchdog_counter_clear_o,
   output logic                      watchdog_prescaler_clear_o,
   input  wire logic                 timeout_event_i,
   input  wire logic                 sleep_event_i,
   output logic                      watchdog_expiry_flag_n_o,
   output logic                      sleep_entered_flag_n_o,
   output logic                      zero_flag_o,
   output logic      [DATA_W-1:0]    acc_o,
   input  wire logic                 load_en_i,
   input  wire logic [FADDR_W-1:0]   load_addr_i,
   input  wire logic [DATA_W-1:0]    load_data_i,
   input  wire logic [FADDR_W-1:0]   peek_addr_i,
   output logic      [DATA_W-1:0]    peek_data_o,
   output logic                      flushing_o
);

   cies_state_type   state_r;
   cies_state_type   state_nxt;
   logic [PC_W-1:0]  pc_r;
   logic [PC_W-1:0]  pc_nxt;
   logic [DATA_W-1:0] acc_r;
   logic [DATA_W-1:0] acc_nxt;
   logic             zero_r;
   logic             zero_nxt;
   logic             expiry_n_r;
   logic             sleep_n_r;
   logic             push_r;
   logic [PC_W-1:0]  stack_top_r;
   logic             kick_r;

   // Decode
   logic             executing;
   cies_op_type      op;
   wire logic [FADDR_W-1:0] f_addr    = instr_i[FADDR_W-1:0];
   wire logic               dest_file = instr_i[`CIES_DEST_BIT];
   wire logic [2:0]         bit_sel   = instr_i[`CIES_BIT_LSB +: 3];
   wire logic [10:0]        imm_addr  = instr_i[10:0];
   wire logic               is_skip   = (instr_i & `CIES_SKIP_MASK) == `CIES_SKIP_MATCH;
   wire logic               is_call   = (instr_i & `CIES_CALL_MASK) == `CIES_CALL_MATCH;
   wire logic               is_indirect_subroutine_op  = instr_i == `CIES_INDIRECT_SUBROUTINE_OP_MATCH;
   wire logic               is_zfile  = (instr_i & `CIES_ZFILE_MASK) == `CIES_ZFILE_MATCH;
   wire logic               is_zacc   = (instr_i & `CIES_ZACC_MASK) == `CIES_ZACC_MATCH;
   wire logic               is_kick   = instr_i == `CIES_KICK_MATCH;
   wire logic               is_inv    = (instr_i & `CIES_INV_MASK) == `CIES_INV_MATCH;
   wire logic               is_dec    = (instr_i & `CIES_DEC_MASK) == `CIES_DEC_MATCH;

   assign executing = run_i && (state_r == CIES_ST_EXEC);

   assign op = is_skip  ? CIES_OP_SKIP  :
               is_call  ? CIES_OP_CALL  :
               is_indirect_subroutine_op ? CIES_OP_INDIRECT_SUBROUTINE_OP :
               is_zfile ? CIES_OP_ZFILE :
               is_zacc  ? CIES_OP_ZACC  :
               is_kick  ? CIES_OP_KICK  :
               (is_inv || is_dec) ? CIES_OP_ALU : CIES_OP_OTHER;

   // Register file and datapath
   logic [DATA_W-1:0] file_val;
   logic              file_we;
   logic [FADDR_W-1:0] file_waddr;
   logic [DATA_W-1:0] file_wdata;

   wire logic [DATA_W-1:0] inv_res   = ~file_val;
   wire logic [DATA_W-1:0] dec_res   = file_val - {{(DATA_W-1){1'b0}}, 1'b1};
   wire logic [DATA_W-1:0] alu_res   = is_inv ? inv_res : dec_res;
   wire logic              tested    = file_val[bit_sel];
   wire logic [PC_W-1:0]   pc_plus1  = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
   wire logic [PC_W-1:0]   pc_plus2  = pc_r + {{(PC_W-2){1'b0}}, 2'b10};
   wire logic [PC_W-1:0]   call_tgt  = {pc_high_latch_i[6:3], imm_addr};
   wire logic [PC_W-1:0]   indirect_subroutine_op_tgt = {pc_high_latch_i[6:0], acc_r};

   // An instruction write has priority; loading is meant for a halted core
   wire logic exec_file_we = executing &&
                             ((op == CIES_OP_ZFILE) || ((op == CIES_OP_ALU) && dest_file));
   assign file_we    = exec_file_we || load_en_i;
   assign file_waddr = exec_file_we ? f_addr : load_addr_i;
   assign file_wdata = !exec_file_we ? load_data_i :
                       (op == CIES_OP_ZFILE) ? '0 : alu_res;

   cies_regfile #(
      .DEPTH  (DEPTH),
      .WIDTH  (DATA_W),
      .ADDR_W (FADDR_W)
   ) u_regfile (
      .clk_i       (clk_i),
      .wr_en_i     (file_we),
      .wr_addr_i   (file_waddr),
      .wr_data_i   (file_wdata),
      .rd_addr_i   (f_addr),
      .rd_data_o   (file_val),
      .peek_addr_i (peek_addr_i),
      .peek_data_o (peek_data_o)
   );

   // Next-state logic
   always_comb begin
      state_nxt = state_r;
      pc_nxt    = pc_r;
      acc_nxt   = acc_r;
      zero_nxt  = zero_r;
      if (run_i) begin
         case (state_r)
            CIES_ST_EXEC: begin
               pc_nxt = pc_plus1;
               case (op)
                  CIES_OP_SKIP: begin
                     // Status untouched
                     if (tested) begin
                        pc_nxt    = pc_plus2;
                        state_nxt = CIES_ST_FLUSH;
                     end
                  end
                  CIES_OP_CALL: begin
                     pc_nxt    = call_tgt;
                     state_nxt = CIES_ST_FLUSH;
                  end
                  CIES_OP_INDIRECT_SUBROUTINE_OP: begin
                     pc_nxt    = indirect_subroutine_op_tgt;
                     state_nxt = CIES_ST_FLUSH;
                  end
                  CIES_OP_ZFILE: begin
                     zero_nxt = 1'b1;
                  end
                  CIES_OP_ZACC: begin
                     acc_nxt  = '0;
                     zero_nxt = 1'b1;
                  end
                  CIES_OP_ALU: begin
                     zero_nxt = (alu_res == '0);
                     if (!dest_file) begin
                        acc_nxt = alu_res;
                     end
                  end
                  default: begin
                  end
               endcase
            end
            CIES_ST_FLUSH: begin
               // Second cycle is a no-op; the program counter already points past it
               state_nxt = CIES_ST_EXEC;
            end
            default: begin
               state_nxt = CIES_ST_EXEC;
            end
         endcase
      end
   end

   wire logic do_push = executing && ((op == CIES_OP_CALL) || (op == CIES_OP_INDIRECT_SUBROUTINE_OP));
   wire logic do_kick = executing && (op == CIES_OP_KICK);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_r <= CIES_ST_EXEC;
         pc_r    <= `CIES_PC_RST;
         acc_r   <= `CIES_ACC_RST;
         zero_r  <= `CIES_ZERO_RST;
      end else begin
         state_r <= state_nxt;
         pc_r    <= pc_nxt;
         acc_r   <= acc_nxt;
         zero_r  <= zero_nxt;
      end
   end

   // Push and kick are registered one-cycle pulses in the cycle after the call or kick executes
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         push_r      <= 1'b0;
         stack_top_r <= `CIES_PC_RST;
         kick_r      <= 1'b0;
      end else begin
         push_r <= do_push;
         kick_r <= do_kick;
         if (do_push) begin
            stack_top_r <= pc_plus1;
         end
      end
   end

   // A kick in the same cycle as an event wins, so the flag reads set
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         expiry_n_r <= `CIES_FLAG_N_RST;
         sleep_n_r  <= `CIES_FLAG_N_RST;
      end else if (do_kick) begin
         expiry_n_r <= 1'b1;
         sleep_n_r  <= 1'b1;
      end else begin
         if (timeout_event_i) begin
            expiry_n_r <= 1'b0;
         end
         if (sleep_event_i) begin
            sleep_n_r <= 1'b0;
         end
      end
   end

   assign pc_o                       = pc_r;
   assign acc_o                      = acc_r;
   assign zero_flag_o                = zero_r;
   assign push_o                     = push_r;
   assign stack_top_o                = stack_top_r;
   assign watchdog_counter_clear_o   = kick_r;
   assign watchdog_prescaler_clear_o = kick_r;
   assign watchdog_expiry_flag_n_o   = expiry_n_r;
   assign sleep_entered_flag_n_o     = sleep_n_r;
   assign flushing_o                 = (state_r == CIES_ST_FLUSH);

endmodule // cies_core

// >>> core/cies_cfg.svh
// Constants of the instruction execution subset: widths, opcode patterns, reset values.
// Assumes 14-bit instruction words and a 15-bit program counter.
`ifndef CIES_CFG_SVH
`define CIES_CFG_SVH

`define CIES_INSTR_W        14
`define CIES_PC_W           15
`define CIES_DATA_W         8
`define CIES_FADDR_W        7
`define CIES_FILE_DEPTH     128
`define CIES_LATCH_W        7

// Opcode masks and match values
`define CIES_SKIP_MASK      14'h3c00
`define CIES_SKIP_MATCH     14'h1c00
`define CIES_CALL_MASK      14'h3800
`define CIES_CALL_MATCH     14'h2000
`define CIES_INDIRECT_SUBROUTINE_OP_MATCH    14'h000a
`define CIES_ZFILE_MASK     14'h3f80
`define CIES_ZFILE_MATCH    14'h0180
`define CIES_ZACC_MASK      14'h3ffc
`define CIES_ZACC_MATCH     14'h0100
`define CIES_KICK_MATCH     14'h0064
`define CIES_INV_MASK       14'h3f00
`define CIES_INV_MATCH      14'h0900
`define CIES_DEC_MASK       14'h3f00
`define CIES_DEC_MATCH      14'h0300

// Field positions
`define CIES_DEST_BIT       7
`define CIES_BIT_LSB        7

// Reset values
`define CIES_PC_RST         15'h0000
`define CIES_ACC_RST        8'h00
`define CIES_ZERO_RST       1'b0
`define CIES_FLAG_N_RST     1'b1

`endif

// >>> core/cies_pkg.sv
// Types shared by the instruction execution subset.
// Assumes cies_cfg.svh is on the include path.
package cies_pkg;

   typedef enum logic [0:0] {
      CIES_ST_EXEC  = 1'b0,
      CIES_ST_FLUSH = 1'b1
   } cies_state_type;

   typedef enum logic [2:0] {
      CIES_OP_OTHER = 3'b000,
      CIES_OP_SKIP  = 3'b001,
      CIES_OP_CALL  = 3'b010,
      CIES_OP_INDIRECT_SUBROUTINE_OP = 3'b011,
      CIES_OP_ZFILE = 3'b100,
      CIES_OP_ZACC  = 3'b101,
      CIES_OP_KICK  = 3'b110,
      CIES_OP_ALU   = 3'b111
   } cies_op_type;

endpackage

// >>> core/cies_regfile.sv
// File register array: one write port, two combinational read ports.
// Assumes a single clock; contents are not reset, as in a real data memory.
`timescale 1ns/1ps
module cies_regfile #(
   parameter int DEPTH  = 128,
   parameter int WIDTH  = 8,
   parameter int ADDR_W = 7
) (
   input  wire logic              clk_i,
   input  wire logic              wr_en_i,
   input  wire logic [ADDR_W-1:0] wr_addr_i,
   input  wire logic [WIDTH-1:0]  wr_data_i,
   input  wire logic [ADDR_W-1:0] rd_addr_i,
   output logic      [WIDTH-1:0]  rd_data_o,
   input  wire logic [ADDR_W-1:0] peek_addr_i,
   output logic      [WIDTH-1:0]  peek_data_o
);

   logic [WIDTH-1:0] mem_r [DEPTH];

   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem_r[wr_addr_i] <= wr_data_i;
      end
   end

   assign rd_data_o   = mem_r[rd_addr_i];
   assign peek_data_o = mem_r[peek_addr_i];

endmodule // cies_regfile

// >>> dv/cies_core_checker.sv
// Port assertions for the execution subset core.
// Assumes the constants of cies_cfg.svh and the core's default widths.
`timescale 1ns/1ps
`include "cies_cfg.svh"
module cies_core_checker (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        run_i,
   input wire logic [13:0] instr_i,
   input wire logic [14:0] pc_o,
   input wire logic [6:0]  pc_high_latch_i,
   input wire logic        push_o,
   input wire logic [14:0] stack_top_o,
   input wire logic        watchdog_counter_clear_o,
   input wire logic        watchdog_prescaler_clear_o,
   input wire logic        watchdog_expiry_flag_n_o,
   input wire logic        sleep_entered_flag_n_o,
   input wire logic        zero_flag_o,
   input wire logic [7:0]  acc_o,
   input wire logic        flushing_o
);
   logic        go;
   logic        is_call;
   logic        is_indirect_subroutine_op;
   logic        keeps_z;
   logic        alu_to_acc;
   logic [14:0] call_tgt_r;
   logic [14:0] indirect_subroutine_op_tgt_r;
   logic [14:0] ret_r;

   assign go = run_i & ~flushing_o;
   assign is_call = (instr_i & `CIES_CALL_MASK) == `CIES_CALL_MATCH;
   assign is_indirect_subroutine_op = instr_i == `CIES_INDIRECT_SUBROUTINE_OP_MATCH;
   assign keeps_z = is_call | is_indirect_subroutine_op | ((instr_i & `CIES_SKIP_MASK) == `CIES_SKIP_MATCH);
   assign alu_to_acc = ~instr_i[7] & (((instr_i & `CIES_INV_MASK) == `CIES_INV_MATCH)
                                     | ((instr_i & `CIES_DEC_MASK) == `CIES_DEC_MATCH));

   // Targets captured at the executing edge, so no sliced $past is needed
   always_ff @(posedge clk_i) begin
      call_tgt_r  <= {pc_high_latch_i[6:3], instr_i[10:0]};
      indirect_subroutine_op_tgt_r <= {pc_high_latch_i, acc_o};
      ret_r       <= pc_o + 15'h0001;
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence kick_s;
      go && instr_i == `CIES_KICK_MATCH;
   endsequence
   sequence kicked_s;
      watchdog_counter_clear_o && watchdog_prescaler_clear_o && watchdog_expiry_flag_n_o && sleep_entered_flag_n_o;
   endsequence

   call_target_a: assert property (go && is_call |=> pc_o == call_tgt_r && flushing_o)
      else $error("direct call target wrong");
   indirect_subroutine_op_target_a: assert property (go && is_indirect_subroutine_op |=> pc_o == indirect_subroutine_op_tgt_r && flushing_o)
      else $error("accumulator call target wrong");
   call_push_a: assert property (go && (is_call || is_indirect_subroutine_op) |=> push_o && stack_top_o == ret_r)
      else $error("return address push wrong");
   flush_once_a: assert property (run_i && flushing_o |=> !flushing_o && $stable(pc_o) && !push_o)
      else $error("flush cycle wrong");
   flags_keep_a: assert property (go && keeps_z |=> $stable(zero_flag_o))
      else $error("zero flag changed by skip or call");
   zero_acc_a: assert property (go && (instr_i & `CIES_ZACC_MASK) == `CIES_ZACC_MATCH |=> acc_o == 8'h00 && zero_flag_o)
      else $error("accumulator clear wrong");
   zero_file_a: assert property (go && (instr_i & `CIES_ZFILE_MASK) == `CIES_ZFILE_MATCH |=> zero_flag_o)
      else $error("file clear left zero flag low");
   watchdog_kick_a: assert property (kick_s |=> kicked_s ##1 !watchdog_counter_clear_o)
      else $error("watchdog kick wrong");
   alu_zero_a: assert property (go && alu_to_acc |=> zero_flag_o == (acc_o == 8'h00))
      else $error("zero flag disagrees with accumulator");
   // A taken skip shows up as a flush cycle, so the step is judged from flushing_o
   skip_step_a: assert property (go && (instr_i & `CIES_SKIP_MASK) == `CIES_SKIP_MATCH
      |=> pc_o == (flushing_o ? ret_r + 15'h0001 : ret_r))
      else $error("skip step wrong");
endmodule // cies_core_checker

bind cies_core cies_core_checker chk (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run_i), .instr_i(instr_i), .pc_o(pc_o),
   .pc_high_latch_i(pc_high_latch_i), .push_o(push_o), .stack_top_o(stack_top_o),
   .watchdog_counter_clear_o(watchdog_counter_clear_o), .watchdog_prescaler_clear_o(watchdog_prescaler_clear_o),
   .watchdog_expiry_flag_n_o(watchdog_expiry_flag_n_o), .sleep_entered_flag_n_o(sleep_entered_flag_n_o),
   .zero_flag_o(zero_flag_o), .acc_o(acc_o), .flushing_o(flushing_o)
);

// >>> dv/tb_top.sv
// Self-checking bench for the execution subset core; words are driven straight onto instr_i.
// Assumes cies_cfg.svh on the include path and the checker bound to the core.
`timescale 1ns/1ps
`include "cies_cfg.svh"
module tb_top;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        run_i = 1'b0;
   logic [13:0] instr_i = 14'h0000;
   logic [6:0]  pc_high_latch_i = 7'h00;
   logic        timeout_event_i = 1'b0;
   logic        sleep_event_i = 1'b0;
   logic        load_en_i = 1'b0;
   logic [6:0]  load_addr_i = 7'h00;
   logic [7:0]  load_data_i = 8'h00;
   logic [6:0]  peek_addr_i = 7'h00;
   logic [14:0] pc_o, stack_top_o, ep, ret;
   logic        push_o, cnt_clr, pre_clr, expiry_n, sleep_n, zero_flag_o, flushing_o;
   logic [7:0]  acc_o, peek_data_o;
   int          miscompares = 0;
   int          tests_run = 0;

   cies_core uut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run_i), .instr_i(instr_i), .pc_o(pc_o),
      .pc_high_latch_i(pc_high_latch_i), .push_o(push_o), .stack_top_o(stack_top_o),
      .watchdog_counter_clear_o(cnt_clr), .watchdog_prescaler_clear_o(pre_clr),
      .timeout_event_i(timeout_event_i), .sleep_event_i(sleep_event_i),
      .watchdog_expiry_flag_n_o(expiry_n), .sleep_entered_flag_n_o(sleep_n), .zero_flag_o(zero_flag_o),
      .acc_o(acc_o), .load_en_i(load_en_i), .load_addr_i(load_addr_i), .load_data_i(load_data_i),
      .peek_addr_i(peek_addr_i), .peek_data_o(peek_data_o), .flushing_o(flushing_o)
   );

   always #50 clk_i = ~clk_i;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Run is held for exactly one edge, so each call executes one word or one flush cycle
   task automatic run1(input logic [13:0] w);
      @(posedge clk_i);
      instr_i <= w;
      run_i <= 1'b1;
      @(posedge clk_i);
      run_i <= 1'b0;
      #1;
   endtask

   task automatic ex(input logic [13:0] w, input logic [14:0] step);
      run1(w);
      ep = ep + step;
      chk("pc", pc_o, ep);
   endtask

   task automatic ld(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_i);
      load_en_i <= 1'b1;
      load_addr_i <= a;
      load_data_i <= d;
      peek_addr_i <= a;
      @(posedge clk_i);
      load_en_i <= 1'b0;
      #1;
   endtask

   task automatic end_of_test;
      if (miscompares == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      ep = 15'h0000;
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      #1;
      chk("reset", {pc_o, acc_o, zero_flag_o, expiry_n, sleep_n, push_o, flushing_o, cnt_clr, pre_clr}, 32'h30);
      ld(7'h05, 8'h81);
      ex(`CIES_INV_MATCH | 14'h0005, 15'h1);
      chk("inv acc", {acc_o, zero_flag_o, peek_data_o}, {8'h7e, 1'b0, 8'h81});
      ex(`CIES_INV_MATCH | 14'h0085, 15'h1);
      chk("inv file", {acc_o, peek_data_o}, {8'h7e, 8'h7e});
      ld(7'h06, 8'h01);
      ex(`CIES_DEC_MATCH | 14'h0006, 15'h1);
      chk("dec acc", {acc_o, zero_flag_o, peek_data_o}, {8'h00, 1'b1, 8'h01});
      ex(`CIES_DEC_MATCH | 14'h0086, 15'h1);
      chk("dec file", {peek_data_o, zero_flag_o}, {8'h00, 1'b1});
      ex(`CIES_DEC_MATCH | 14'h0086, 15'h1);
      chk("dec wrap", {peek_data_o, zero_flag_o, acc_o}, {8'hff, 1'b0, 8'h00});
      for (int i = 0; i < 4; i++) begin
         ex(`CIES_INV_MATCH | 14'h0005, 15'h1);
         ex(`CIES_ZACC_MATCH | 14'(i), 15'h1);
         chk("clr acc", {acc_o, zero_flag_o}, {8'h00, 1'b1});
      end
      ex(`CIES_INV_MATCH | 14'h0005, 15'h1);
      ex(`CIES_ZFILE_MATCH | 14'h0006, 15'h1);
      chk("clr file", {peek_data_o, zero_flag_o, acc_o}, {8'h00, 1'b1, 8'h81});
      ld(7'h07, 8'h80);
      ex(`CIES_INV_MATCH | 14'h0005, 15'h1);
      ex(`CIES_SKIP_MATCH | 14'h0387, 15'h2);
      chk("skip flush", flushing_o, 1'b1);
      ex(`CIES_DEC_MATCH | 14'h0007, 15'h0);
      chk("skipped word", {acc_o, zero_flag_o, flushing_o}, {8'h81, 1'b0, 1'b0});
      ex(`CIES_SKIP_MATCH | 14'h0007, 15'h1);
      chk("no skip", flushing_o, 1'b0);
      ex(`CIES_DEC_MATCH | 14'h0007, 15'h1);
      chk("next runs", acc_o, 8'h7f);
      @(posedge clk_i);
      pc_high_latch_i <= 7'h55;
      ret = ep + 15'h1;
      run1(`CIES_CALL_MATCH | 14'h07a3);
      ep = {4'ha, 11'h7a3};
      chk("call pc", pc_o, ep);
      chk("call push", {push_o, flushing_o, stack_top_o, zero_flag_o}, {2'b11, ret, 1'b0});
      ex(`CIES_DEC_MATCH | 14'h0007, 15'h0);
      chk("call flush", {push_o, flushing_o, acc_o}, {2'b00, 8'h7f});
      @(posedge clk_i);
      pc_high_latch_i <= 7'h2c;
      ret = ep + 15'h1;
      run1(`CIES_INDIRECT_SUBROUTINE_OP_MATCH);
      ep = {7'h2c, 8'h7f};
      chk("indirect_subroutine_op pc", pc_o, ep);
      chk("indirect_subroutine_op push", {push_o, flushing_o, stack_top_o, zero_flag_o}, {2'b11, ret, 1'b0});
      ex(14'h0000, 15'h0);
      @(posedge clk_i);
      timeout_event_i <= 1'b1;
      sleep_event_i <= 1'b1;
      @(posedge clk_i);
      timeout_event_i <= 1'b0;
      sleep_event_i <= 1'b0;
      #1;
      chk("events", {expiry_n, sleep_n}, 2'b00);
      ex(`CIES_KICK_MATCH, 15'h1);
      chk("kick", {cnt_clr, pre_clr, expiry_n, sleep_n}, 4'hf);
      ex(14'h0000, 15'h1);
      chk("kick end", {cnt_clr, pre_clr, expiry_n, sleep_n}, 4'h3);
      // Kick and both events on one edge: the kick must leave the flags set
      @(posedge clk_i);
      timeout_event_i <= 1'b1;
      sleep_event_i <= 1'b1;
      instr_i <= `CIES_KICK_MATCH;
      run_i <= 1'b1;
      @(posedge clk_i);
      timeout_event_i <= 1'b0;
      sleep_event_i <= 1'b0;
      run_i <= 1'b0;
      #1;
      chk("kick wins", {cnt_clr, pre_clr, expiry_n, sleep_n}, 4'hf);
      end_of_test();
   end

   // About 80 cycles are needed; the limit leaves wide margin
   initial begin
      #1000000;
      miscompares++;
      end_of_test();
   end
endmodule // tb_top
